// file: rtl/pllcb_bank.sv
/*
  Configuration register bank for the first synthesis loop: loop
  filter sets, slip detector, charge pump, feedback dividers, input
  clock choice and the program/active state machine.
  Assumes a single-cycle register port on clk_sys and synchronous
  pin inputs.
*/
// Design decision made here: strobed register access.
// How it works
// R1: Escape bit written while active returns state machine to program state.
// R2: Software writes code 1Bh to directive field to enter active state.
// R3: Misc bit 0 picks fractional (0) or integer-only (1) feedback divide.
// R4: Bit 7 at 17h disables the PLL and all its functions; code gates only enable, slip, offset, dither, clock choice.
// R5: Feedback integer is 17h bits 6:0 extended by 18h bit 4.
// R6: Bytes 1Ah..1Ch form the fractional part of the feedback ratio.
// R7: Bytes 1Dh and 1Eh form the second divider's integer ratio.
// R8: 16h bit 0 enables slip detector, using threshold in bits 2:1.
// R9: In manual mode with 18h bit 5 set, pins choose the clock.
// R10: 1Fh bit 6 forces manual clock choice over the automatic one.
// R11: Loop filter sets at 10h..12h, fast-lock copies at 13h..15h.
// R12: 18h bit 6 enables pump offset, bit 7 enables converter dither.
// R13: 18h bits 3:1 hold the charge pump binning code.
// R14: 16h bit 3 is zero-delay mode; bits 5:4 loop filter config.
// R15: 16h bit 7 holds the charge pump gain setting.
// R16: Everything resets to zero; reserved bits read zero, ignore writes.
`timescale 1ns/1ns
module pllcb_bank
  import pllcb_pkg::*;
#(
  parameter int SEL_W = 2
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  // Register port
  input  wire logic [7:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [7:0]       reg_rdata,
  // Loop context
  input  wire logic             fast_lock_mode,
  input  wire logic [SEL_W-1:0] manual_sel_pins,
  input  wire logic [SEL_W-1:0] auto_clk_sel,
  // State
  output logic                  active_state,
  output logic                  pll_enable,
  // Loop filter
  output logic      [7:0]       dlf_prop_cfg,
  output logic      [15:0]      dlf_int_cfg,
  output logic                  slip_det_en,
  output logic      [1:0]       slip_det_thresh,
  output logic                  zero_delay_mode,
  output logic      [1:0]       loop_filter_cfg,
  // Charge pump and converter
  output logic                  cp_gain_cfg,
  output logic                  cp_offset_en,
  output logic                  dither_en,
  output logic      [2:0]       cp_bin_code,
  // Feedback dividers
  output logic                  fb_int_mode,
  output logic      [7:0]       fb_int,
  output logic      [23:0]      fb_frac,
  output logic      [15:0]      fb2_int,
  // Input clock choice
  output logic      [SEL_W-1:0] active_clk_sel
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_sync_n;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_n <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Writable bits per offset; also used to blank reserved bits on read
  function automatic logic [7:0] wmask(input logic [7:0] addr);
    logic [7:0] m;
    m = PLLCB_NO_WMASK;
    if (addr == PLLCB_ADDR_DIRECTIVE) begin
      m = PLLCB_DIR_WMASK;
    end else if (addr[7:4] == PLLCB_BANK_PAGE) begin
      if (addr == PLLCB_ADDR_HOLE) begin
        m = PLLCB_NO_WMASK;
      end else if (addr == PLLCB_ADDR_FB2_INT3) begin
        m = PLLCB_INT3_WMASK;
      end else begin
        m = PLLCB_FULL_WMASK;
      end
    end
    return m;
  endfunction

  logic       in_bank;
  logic [7:0] wr_mask;

  assign in_bank = reg_addr[7:4] == PLLCB_BANK_PAGE;
  assign wr_mask = wmask(reg_addr);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [7:0] bank_q [16];
  logic [7:0] dir_q;

  for (genvar i = 0; i < 16; i++) begin : g_bank
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        bank_q[i] <= PLLCB_REG_RESET;                 // [R16]
      end else if (reg_wr && in_bank && reg_addr[3:0] == 4'(i)) begin
        bank_q[i] <= reg_wdata & wr_mask;             // [R16]
      end
    end
  end

  // Escape bit is an action, so it never stays set in storage
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      dir_q <= PLLCB_REG_RESET;
    end else if (reg_wr && reg_addr == PLLCB_ADDR_DIRECTIVE) begin
      dir_q <= reg_wdata & wr_mask & ~(8'h01 << PLLCB_DIR_ESC_BIT);
    end
  end

  logic [7:0] r_slip;
  logic [7:0] r_fbint;
  logic [7:0] r_misc;
  logic [7:0] r_int3;

  assign r_slip  = bank_q[PLLCB_ADDR_SLIP[3:0]];
  assign r_fbint = bank_q[PLLCB_ADDR_FB_INT[3:0]];
  assign r_misc  = bank_q[PLLCB_ADDR_MISC[3:0]];
  assign r_int3  = bank_q[PLLCB_ADDR_FB2_INT3[3:0]];

  // ----------------------------------------------------------------
  // Program / active state machine
  // ----------------------------------------------------------------
  pllcb_state_e state_q;
  logic         dir_wr;
  logic         esc_req;
  logic         go_req;

  assign dir_wr  = reg_wr && reg_addr == PLLCB_ADDR_DIRECTIVE;
  assign esc_req = dir_wr && reg_wdata[PLLCB_DIR_ESC_BIT];
  assign go_req  = dir_wr &&
                   reg_wdata[7:PLLCB_DIR_CMD_LSB] == PLLCB_CMD_GO_ACTIVE;

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_q <= PLLCB_ST_PROGRAM;
    end else begin
      case (state_q)
        PLLCB_ST_PROGRAM: begin
          // Entry relies on software issuing the go-active code
          if (go_req) begin                           // [R2]
            state_q <= PLLCB_ST_ACTIVE;
          end
        end
        PLLCB_ST_ACTIVE: begin
          if (esc_req) begin                          // [R1]
            state_q <= PLLCB_ST_PROGRAM;
          end
        end
        default: begin
          state_q <= PLLCB_ST_PROGRAM;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  logic       running;
  logic [7:0] rd_val;

  assign running = state_q == PLLCB_ST_ACTIVE &&
                   !r_fbint[PLLCB_MDIS_BIT];          // [R4]

  always_comb begin
    rd_val = '0;
    if (reg_addr == PLLCB_ADDR_STATUS) begin
      rd_val = {6'h00, running, state_q == PLLCB_ST_ACTIVE};
    end else if (reg_addr == PLLCB_ADDR_DIRECTIVE) begin
      rd_val = dir_q;
    end else if (in_bank) begin
      rd_val = bank_q[reg_addr[3:0]] & wr_mask;       // [R16]
    end
  end

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= rd_val;
    end else begin
      reg_rdata <= '0;
    end
  end

  // ----------------------------------------------------------------
  // State, loop filter and charge pump outputs
  // ----------------------------------------------------------------
  // Registered so that the analog side never sees a decode glitch
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      active_state    <= 1'b0;
      pll_enable      <= 1'b0;
      dlf_prop_cfg    <= '0;
      dlf_int_cfg     <= '0;
      slip_det_en     <= 1'b0;
      slip_det_thresh <= '0;
      zero_delay_mode <= 1'b0;
      loop_filter_cfg <= '0;
      cp_gain_cfg     <= 1'b0;
      cp_offset_en    <= 1'b0;
      dither_en       <= 1'b0;
      cp_bin_code     <= '0;
    end else begin
      active_state <= state_q == PLLCB_ST_ACTIVE;
      pll_enable   <= !r_fbint[PLLCB_MDIS_BIT];       // [R4]
      if (fast_lock_mode) begin                       // [R11]
        dlf_prop_cfg <= bank_q[PLLCB_ADDR_QL_PROP[3:0]];
        dlf_int_cfg  <= {bank_q[PLLCB_ADDR_QL_INT_B[3:0]],
                         bank_q[PLLCB_ADDR_QL_INT_A[3:0]]};
      end else begin
        dlf_prop_cfg <= bank_q[PLLCB_ADDR_PROP[3:0]];
        dlf_int_cfg  <= {bank_q[PLLCB_ADDR_INT_B[3:0]],
                         bank_q[PLLCB_ADDR_INT_A[3:0]]};
      end
      // Master disable silences the slip detector, pump offset and dither
      slip_det_en     <= !r_fbint[PLLCB_MDIS_BIT] &&
                         r_slip[PLLCB_SLIP_EN_BIT];   // [R8] [R4]
      slip_det_thresh <= (!r_fbint[PLLCB_MDIS_BIT] &&
                          r_slip[PLLCB_SLIP_EN_BIT]) ?
                         r_slip[PLLCB_SLIP_THR_LSB +: 2] : 2'b00; // [R8]
      zero_delay_mode <= r_slip[PLLCB_ZDM_BIT];       // [R14]
      loop_filter_cfg <= r_slip[PLLCB_LF_CFG_LSB +: 2]; // [R14]
      cp_gain_cfg     <= r_slip[PLLCB_CP_GAIN_BIT];   // [R15]
      cp_offset_en    <= !r_fbint[PLLCB_MDIS_BIT] &&
                         r_misc[PLLCB_CP_OFS_BIT];    // [R12]
      dither_en       <= !r_fbint[PLLCB_MDIS_BIT] &&
                         r_misc[PLLCB_DITHER_BIT];    // [R12]
      cp_bin_code     <= r_misc[PLLCB_CP_BIN_LSB +: 3]; // [R13]
    end
  end

  // ----------------------------------------------------------------
  // Feedback divider outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      fb_int_mode <= 1'b0;
      fb_int      <= '0;
      fb_frac     <= '0;
      fb2_int     <= '0;
    end else begin
      fb_int_mode <= r_misc[PLLCB_INT_MODE_BIT];      // [R3]
      fb_int      <= {r_misc[PLLCB_INT_EXT_BIT],
                      r_fbint[6:0]};                  // [R5]
      // Integer mode keeps the modulator at a zero fraction
      if (r_misc[PLLCB_INT_MODE_BIT]) begin           // [R3]
        fb_frac <= '0;
      end else begin
        fb_frac <= {bank_q[PLLCB_ADDR_FRAC2[3:0]],
                    bank_q[PLLCB_ADDR_FRAC3[3:0]],
                    bank_q[PLLCB_ADDR_FRAC4[3:0]]};   // [R6]
      end
      fb2_int     <= {bank_q[PLLCB_ADDR_FB2_INT2[3:0]],
                      bank_q[PLLCB_ADDR_FB2_INT1[3:0]]}; // [R7]
    end
  end

  // ----------------------------------------------------------------
  // Input clock choice
  // ----------------------------------------------------------------
  pllcb_clk_select #(
    .SEL_W (SEL_W)
  ) u_clk_select (
    .clk_sys      (clk_sys),
    .rst_sync_n   (rst_sync_n),
    .force_manual (r_int3[PLLCB_FORCE_MAN_BIT]),      // [R10]
    .pin_sel_en   (r_misc[PLLCB_PIN_SEL_BIT]),        // [R9]
    .run_en       (!r_fbint[PLLCB_MDIS_BIT]),
    .manual_pins  (manual_sel_pins),
    .auto_sel     (auto_clk_sel),
    .active_sel   (active_clk_sel)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_escape_to_program : assert property ( // [R1]
    @(posedge clk_sys) disable iff (!rst_sync_n)
    state_q == PLLCB_ST_ACTIVE && esc_req |=> ##1 !active_state)
    else $error("escape did not return to program state");

  chk_go_active_code : assert property ( // [R2]
    @(posedge clk_sys) disable iff (!rst_sync_n)
    state_q == PLLCB_ST_PROGRAM && go_req |=> ##1 active_state)
    else $error("go-active code did not enter active state");

  chk_int_mode_frac : assert property ( // [R3]
    @(posedge clk_sys) disable iff (!rst_sync_n)
    reg_wr && reg_addr == PLLCB_ADDR_MISC && reg_wdata[0] |=>
      ##1 fb_int_mode && fb_frac == 24'h000000)
    else $error("integer mode did not clear the fraction");

  chk_master_disable : assert property ( // [R4]
    @(posedge clk_sys) disable iff (!rst_sync_n)
    reg_wr && reg_addr == PLLCB_ADDR_FB_INT && reg_wdata[7] |=>
      ##1 !pll_enable && !slip_det_en && !cp_offset_en && !dither_en)
    else $error("master disable left a function running");

  chk_int_value : assert property ( // [R5]
    @(posedge clk_sys) disable iff (!rst_sync_n)
    reg_wr && reg_addr == PLLCB_ADDR_FB_INT |=>
      ##1 fb_int[6:0] == $past(reg_wdata[6:0], 2))
    else $error("feedback integer not applied");

  chk_frac_msb : assert property ( // [R6]
    @(posedge clk_sys) disable iff (!rst_sync_n)
    reg_wr && reg_addr == PLLCB_ADDR_FRAC2 && !r_misc[0] &&
      !(reg_wr && reg_addr == PLLCB_ADDR_MISC) |=>
      ##1 fb_frac[23:16] == $past(reg_wdata, 2))
    else $error("fraction byte not applied");

  chk_fb2_low : assert property ( // [R7]
    @(posedge clk_sys) disable iff (!rst_sync_n)
    reg_wr && reg_addr == PLLCB_ADDR_FB2_INT1 |=>
      ##1 fb2_int[7:0] == $past(reg_wdata, 2))
    else $error("second divider integer not applied");

  chk_slip_thresh : assert property ( // [R8]
    @(posedge clk_sys) disable iff (!rst_sync_n)
    slip_det_thresh == (slip_det_en ?
      $past(r_slip[PLLCB_SLIP_THR_LSB +: 2]) : 2'b00))
    else $error("threshold does not follow the enabled detector");

  chk_reserved_read : assert property ( // [R16]
    @(posedge clk_sys) disable iff (!rst_sync_n)
    reg_rd && reg_addr == PLLCB_ADDR_FB2_INT3 |=>
      reg_rdata[7] == 1'b0 && reg_rdata[5:0] == 6'h00)
    else $error("reserved bits read nonzero");

  chk_read_one_cycle : assert property ( // [R16]
    @(posedge clk_sys) disable iff (!rst_sync_n)
    !$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its cycle");

endmodule

// file: rtl/pllcb_pkg.sv
/*
  Constants for the PLL loop and divider configuration bank: register
  offsets, field positions, reset values and directive codes.
  Assumes 8-bit registers on an 8-bit address space.
*/
package pllcb_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] PLLCB_ADDR_STATUS    = 8'h0E;
  localparam logic [7:0] PLLCB_ADDR_DIRECTIVE = 8'h0F;
  localparam logic [7:0] PLLCB_ADDR_PROP      = 8'h10;
  localparam logic [7:0] PLLCB_ADDR_INT_A     = 8'h11;
  localparam logic [7:0] PLLCB_ADDR_INT_B     = 8'h12;
  localparam logic [7:0] PLLCB_ADDR_QL_PROP   = 8'h13;
  localparam logic [7:0] PLLCB_ADDR_QL_INT_A  = 8'h14;
  localparam logic [7:0] PLLCB_ADDR_QL_INT_B  = 8'h15;
  localparam logic [7:0] PLLCB_ADDR_SLIP      = 8'h16;
  localparam logic [7:0] PLLCB_ADDR_FB_INT    = 8'h17;
  localparam logic [7:0] PLLCB_ADDR_MISC      = 8'h18;
  localparam logic [7:0] PLLCB_ADDR_HOLE      = 8'h19;
  localparam logic [7:0] PLLCB_ADDR_FRAC2     = 8'h1A;
  localparam logic [7:0] PLLCB_ADDR_FRAC3     = 8'h1B;
  localparam logic [7:0] PLLCB_ADDR_FRAC4     = 8'h1C;
  localparam logic [7:0] PLLCB_ADDR_FB2_INT1  = 8'h1D;
  localparam logic [7:0] PLLCB_ADDR_FB2_INT2  = 8'h1E;
  localparam logic [7:0] PLLCB_ADDR_FB2_INT3  = 8'h1F;

  // Bank of 0x10..0x1F sits at one upper nibble
  localparam logic [3:0] PLLCB_BANK_PAGE      = 4'h1;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PLLCB_DIR_CMD_LSB    = 3;
  localparam int PLLCB_DIR_SPARE_BIT  = 2;
  localparam int PLLCB_DIR_ESC_BIT    = 1;
  localparam int PLLCB_SLIP_EN_BIT    = 0;
  localparam int PLLCB_SLIP_THR_LSB   = 1;
  localparam int PLLCB_ZDM_BIT        = 3;
  localparam int PLLCB_LF_CFG_LSB     = 4;
  localparam int PLLCB_CP_GAIN_BIT    = 7;
  localparam int PLLCB_MDIS_BIT       = 7;
  localparam int PLLCB_INT_MODE_BIT   = 0;
  localparam int PLLCB_CP_BIN_LSB     = 1;
  localparam int PLLCB_INT_EXT_BIT    = 4;
  localparam int PLLCB_PIN_SEL_BIT    = 5;
  localparam int PLLCB_CP_OFS_BIT     = 6;
  localparam int PLLCB_DITHER_BIT     = 7;
  localparam int PLLCB_FORCE_MAN_BIT  = 6;

  // ----------------------------------------------------------------
  // Codes, masks and reset values
  // ----------------------------------------------------------------
  localparam logic [4:0] PLLCB_CMD_GO_ACTIVE = 5'h1B;
  localparam logic [7:0] PLLCB_DIR_WMASK     = 8'hFC;
  localparam logic [7:0] PLLCB_FULL_WMASK    = 8'hFF;
  localparam logic [7:0] PLLCB_INT3_WMASK    = 8'h40;
  localparam logic [7:0] PLLCB_NO_WMASK      = 8'h00;
  localparam logic [7:0] PLLCB_REG_RESET     = 8'h00;

  typedef enum logic {
    PLLCB_ST_PROGRAM,
    PLLCB_ST_ACTIVE
  } pllcb_state_e;

endpackage

// file: rtl/pllcb_clk_select.sv
/*
  Active input clock chooser. While run_en is high, follows the automatic choice unless
  manual selection is forced; then takes the select pins when pin
  selection is enabled and otherwise holds the last choice.
  Assumes all inputs synchronous to clk_sys.
*/
`timescale 1ns/1ns
module pllcb_clk_select
  import pllcb_pkg::*;
#(
  parameter int SEL_W = 2
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_sync_n,
  // Control
  input  wire logic             force_manual,
  input  wire logic             pin_sel_en,
  input  wire logic             run_en,
  // Candidate selections
  input  wire logic [SEL_W-1:0] manual_pins,
  input  wire logic [SEL_W-1:0] auto_sel,
  // Result
  output logic      [SEL_W-1:0] active_sel
);

  logic [SEL_W-1:0] sel_q;

  // ----------------------------------------------------------------
  // Selection register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sel_q <= '0;
    end else if (run_en) begin
      if (force_manual) begin                         // [R10]
        if (pin_sel_en) begin
          sel_q <= manual_pins;                       // [R9]
        end
      end else begin
        sel_q <= auto_sel;
      end
    end
  end

  assign active_sel = sel_q;

  chk_manual_pin_follow : assert property ( // [R9]
    @(posedge clk_sys) disable iff (!rst_sync_n)
    run_en && force_manual && pin_sel_en |=>
      active_sel == $past(manual_pins))
    else $error("manual pin selection not taken");

  chk_force_overrides : assert property ( // [R10]
    @(posedge clk_sys) disable iff (!rst_sync_n)
    run_en && force_manual && !pin_sel_en |=> $stable(active_sel))
    else $error("automatic choice leaked past forced manual mode");

endmodule

// file: dv/tb_pllcb_bank.sv
/*
  Self-checking bench for the PLL loop and divider configuration bank.
  Assumes the single-cycle register port of the bank and drives every
  input itself on the rising edge of clk_sys.
*/
`timescale 1ns/1ns
module tb_pllcb_bank
  import pllcb_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clk_sys, rst_n, reg_wr, reg_rd, fast_lock_mode;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, dlf_prop_cfg, fb_int;
  logic [1:0]  manual_sel_pins, auto_clk_sel, active_clk_sel;
  logic        active_state, pll_enable, slip_det_en, zero_delay_mode;
  logic [1:0]  slip_det_thresh, loop_filter_cfg;
  logic        cp_gain_cfg, cp_offset_en, dither_en, fb_int_mode;
  logic [2:0]  cp_bin_code;
  logic [15:0] dlf_int_cfg, fb2_int;
  logic [23:0] fb_frac;
  int          mismatches, n_compared, cycles;

  pllcb_bank #(.SEL_W(2)) uut (.clk_sys(clk_sys), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .fast_lock_mode(fast_lock_mode), .manual_sel_pins(manual_sel_pins),
    .auto_clk_sel(auto_clk_sel), .active_state(active_state),
    .pll_enable(pll_enable), .dlf_prop_cfg(dlf_prop_cfg),
    .dlf_int_cfg(dlf_int_cfg), .slip_det_en(slip_det_en),
    .slip_det_thresh(slip_det_thresh), .zero_delay_mode(zero_delay_mode),
    .loop_filter_cfg(loop_filter_cfg), .cp_gain_cfg(cp_gain_cfg),
    .cp_offset_en(cp_offset_en), .dither_en(dither_en),
    .cp_bin_code(cp_bin_code), .fb_int_mode(fb_int_mode), .fb_int(fb_int),
    .fb_frac(fb_frac), .fb2_int(fb2_int), .active_clk_sel(active_clk_sel));

  // ----------------------------------------------------------------
  // Clock, timeout and helpers
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // Whole run needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches = mismatches + 1;
      close_out();
    end
  end

  task automatic close_out();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      mismatches = mismatches + 1;
    end
  endtask

  // Strobe dropped one edge later; a new call waits a further edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic chkr(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk({active_state, dlf_prop_cfg, dlf_int_cfg, slip_det_en,
         slip_det_thresh, zero_delay_mode, loop_filter_cfg, cp_gain_cfg,
         cp_offset_en, dither_en, cp_bin_code, fb_int_mode}, 64'h0);
    chk({fb_int, fb_frac, fb2_int}, 64'h0);
    for (int a = 8'h0E; a <= 8'h1F; a++) chkr(a[7:0], 8'h00);
    $display("t_reset done");
  endtask

  task automatic t_regs();
    logic [7:0] v;
    for (int a = 8'h10; a <= 8'h1F; a++) begin
      v = 8'h5A ^ a[7:0];
      wr(a[7:0], v);
      if (a == 8'h19) chkr(a[7:0], 8'h00);
      else if (a == 8'h1F) chkr(a[7:0], v & PLLCB_INT3_WMASK);
      else chkr(a[7:0], v);
    end
    wr(8'h20, 8'hFF);
    chkr(8'h20, 8'h00);
    wr(PLLCB_ADDR_STATUS, 8'hFF);
    chkr(PLLCB_ADDR_STATUS, 8'h00);
    for (int a = 8'h10; a <= 8'h1F; a++) wr(a[7:0], 8'h00);
    $display("t_regs done");
  endtask

  task automatic t_loop();
    for (int a = 0; a < 6; a++) wr(8'h10 + a[7:0], 8'h31 + 8'h11 * a[7:0]);
    settle(2);
    chk({dlf_prop_cfg, dlf_int_cfg}, 24'h315342);
    @(posedge clk_sys);
    fast_lock_mode <= 1'b1;
    settle(2);
    chk({dlf_prop_cfg, dlf_int_cfg}, 24'h648675);
    @(posedge clk_sys);
    fast_lock_mode <= 1'b0;
    $display("t_loop done");
  endtask

  task automatic t_slip();
    wr(PLLCB_ADDR_SLIP, 8'hBF);
    settle(2);
    chk({slip_det_en, slip_det_thresh}, 3'h7);
    chk({zero_delay_mode, loop_filter_cfg, cp_gain_cfg}, 4'hF);
    wr(PLLCB_ADDR_SLIP, 8'h06);
    settle(2);
    chk({slip_det_en, slip_det_thresh, zero_delay_mode}, 4'h0);
    chk({loop_filter_cfg, cp_gain_cfg}, 3'h0);
    $display("t_slip done");
  endtask

  task automatic t_fb();
    wr(PLLCB_ADDR_FRAC2, 8'hAB);
    wr(PLLCB_ADDR_FRAC3, 8'hCD);
    wr(PLLCB_ADDR_FRAC4, 8'hEF);
    wr(PLLCB_ADDR_FB2_INT1, 8'h34);
    wr(PLLCB_ADDR_FB2_INT2, 8'h12);
    wr(PLLCB_ADDR_FB_INT, 8'h7F);
    wr(PLLCB_ADDR_MISC, 8'hDB);
    settle(2);
    chk({fb_int_mode, cp_bin_code}, 4'hD);
    chk({dither_en, cp_offset_en}, 2'h3);
    chk(fb_int, 8'hFF);
    chk(fb_frac, 24'h0);
    chk(fb2_int, 16'h1234);
    wr(PLLCB_ADDR_MISC, 8'h00);
    settle(2);
    chk({fb_int_mode, fb_int}, 9'h07F);
    chk(fb_frac, 24'hABCDEF);
    wr(PLLCB_ADDR_FB_INT, 8'h00);
    $display("t_fb done");
  endtask

  task automatic t_disable();
    wr(PLLCB_ADDR_SLIP, 8'h01);
    wr(PLLCB_ADDR_MISC, 8'hC0);
    wr(PLLCB_ADDR_FB_INT, 8'h80);
    settle(2);
    chk({pll_enable, slip_det_en, cp_offset_en, dither_en}, 4'h0);
    wr(PLLCB_ADDR_FB_INT, 8'h00);
    settle(2);
    chk({pll_enable, slip_det_en, cp_offset_en, dither_en}, 4'hF);
    wr(PLLCB_ADDR_SLIP, 8'h00);
    wr(PLLCB_ADDR_MISC, 8'h00);
    $display("t_disable done");
  endtask

  task automatic t_clk();
    @(posedge clk_sys);
    auto_clk_sel    <= 2'h2;
    manual_sel_pins <= 2'h3;
    settle(2);
    chk(active_clk_sel, 2'h2);
    wr(PLLCB_ADDR_MISC, 8'h20);
    wr(PLLCB_ADDR_FB2_INT3, 8'h40);
    settle(3);
    chk(active_clk_sel, 2'h3);
    wr(PLLCB_ADDR_MISC, 8'h00);
    settle(3);
    @(posedge clk_sys);
    manual_sel_pins <= 2'h1;
    auto_clk_sel    <= 2'h0;
    settle(2);
    chk(active_clk_sel, 2'h3);
    wr(PLLCB_ADDR_FB2_INT3, 8'h00);
    settle(3);
    chk(active_clk_sel, 2'h0);
    $display("t_clk done");
  endtask

  task automatic t_state();
    wr(PLLCB_ADDR_DIRECTIVE, 8'hC0);
    settle(2);
    chk(active_state, 1'b0);
    wr(PLLCB_ADDR_DIRECTIVE, {PLLCB_CMD_GO_ACTIVE, 3'b000});
    settle(2);
    chk(active_state, 1'b1);
    chkr(PLLCB_ADDR_STATUS, 8'h03);
    chkr(PLLCB_ADDR_DIRECTIVE, 8'hD8);
    wr(PLLCB_ADDR_DIRECTIVE, 8'h02);
    settle(2);
    chk(active_state, 1'b0);
    chkr(PLLCB_ADDR_DIRECTIVE, 8'h00);
    chkr(PLLCB_ADDR_STATUS, 8'h00);
    $display("t_state done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    mismatches      = 0;
    n_compared      = 0;
    cycles          = 0;
    rst_n           = 1'b0;
    reg_wr          = 1'b0;
    reg_rd          = 1'b0;
    reg_addr        = 8'h00;
    reg_wdata       = 8'h00;
    fast_lock_mode  = 1'b0;
    manual_sel_pins = 2'h0;
    auto_clk_sel    = 2'h0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    // Internal reset lifts two edges after release
    settle(3);
    t_reset();
    t_regs();
    t_loop();
    t_slip();
    t_fb();
    t_disable();
    t_clk();
    t_state();
    close_out();
  end
endmodule
